/* rtl/dppc_consts.svh */
// Constants of the display pixel path: field positions, sizes and widths.
// Assumes inclusion by the package and by every module that uses them.
`ifndef DPPC_CONSTS_SVH
`define DPPC_CONSTS_SVH

// ==========================================================
// Pixel and framebuffer fields
`define DPPC_FB_W 128
`define DPPC_PIX_W 32
`define DPPC_BYPASS_BIT 31
`define DPPC_COL_W 30
`define DPPC_LUT_DEPTH 256
`define DPPC_LUT_AW 8

// ==========================================================
// Cursor geometry and fetch
`define DPPC_CUR_MODE_BIT 15
`define DPPC_CUR_DIM 32
`define DPPC_CUR_WORDS 1024
`define DPPC_CUR_IDX_W 10
`define DPPC_CUR_BYTES 2048
`define DPPC_CUR_INV 16'h7FFF

// ==========================================================
// Counters, addresses, line store
`define DPPC_ADDR_W 24
`define DPPC_CNT_W 12
`define DPPC_LINE_MAX 2048
`define DPPC_LANE_W 2

`endif

/* rtl/dppc_cursor_mix.sv */
// Cursor merge: widens 5:5:5 cursor colour and blends it onto a pixel.
// Assumes the caller gives a pixel that already holds any overlay video.
`timescale 1ns/1ps
`include "dppc_consts.svh"
module dppc_cursor_mix (
	// Cursor side
	input wire logic hit,
	input wire logic [15:0] curPix,
	// Display side
	input wire logic [`DPPC_COL_W-1:0] under,
	output logic [`DPPC_COL_W-1:0] mixed
);
	logic [`DPPC_COL_W-1:0] wide;

	// ==========================================================
	// Each 5-bit part repeated into upper and lower halves
	assign wide = {curPix[14:10], curPix[14:10], curPix[9:5], curPix[9:5],
		curPix[4:0], curPix[4:0]};

	// Zero is see-through; all colour bits with mode clear inverts via XOR
	always_comb begin
		if (!hit || curPix == 16'h0000) begin
			mixed = under;
		end else if (curPix[`DPPC_CUR_MODE_BIT]) begin
			mixed = wide;
		end else begin
			mixed = under ^ wide;
		end
	end
endmodule

/* rtl/dppc_pixel_decode.sv */
// Decoder for 32-bit direct colour pixels, with the gamma lookup table.
// Assumes table writes come from software in the clk domain.
`timescale 1ns/1ps
`include "dppc_consts.svh"
module dppc_pixel_decode (
	// Clock for table writes
	input wire logic clk,
	// Pixel in
	input wire logic [`DPPC_PIX_W-1:0] pixel,
	// Table write port
	input wire logic lutWe,
	input wire logic [`DPPC_LUT_AW-1:0] lutAddr,
	input wire logic [23:0] lutData,
	// 10:10:10 colour out
	output logic [`DPPC_COL_W-1:0] color
);
	logic [23:0] lut [`DPPC_LUT_DEPTH];
	logic [23:0] entR, entG, entB;

	// ==========================================================
	// Table store, no reset: software must load it before use
	always_ff @(posedge clk) begin
		if (lutWe) begin
			lut[lutAddr] <= lutData;
		end
	end

	// Each colour has its own lookup; bits 30:24 play no part here
	assign entR = lut[pixel[23:16]];
	assign entG = lut[pixel[15:8]];
	assign entB = lut[pixel[7:0]];

	// ==========================================================
	// Select bit chooses bypass or table path
	always_comb begin
		if (pixel[`DPPC_BYPASS_BIT]) begin
			// Low bits live apart in the top byte; bit 30 unused
			color = {pixel[23:16], pixel[29:28], pixel[15:8], pixel[27:26],
				pixel[7:0], pixel[25:24]};
		end else begin
			// Table gives 8 bits; low two bits of each DAC input stay zero
			color = {entR[23:16], 2'h0, entG[15:8], 2'h0, entB[7:0], 2'h0};
		end
	end
endmodule

/* rtl/dppc_pkg.sv */
// Types used by the display pixel path top module.
// Assumes the constants header sits beside it in rtl/.
package dppc_pkg;
`include "dppc_consts.svh"

	// ==========================================================
	// Cursor bitmap fetch states
	typedef enum logic [1:0] {FETCH_IDLE, FETCH_REQ, FETCH_WAIT} dppc_fetch_t;

	// ==========================================================
	// Register state of the top module, apart from the line and cursor image stores
	typedef struct packed {
		logic [`DPPC_CNT_W-1:0] hCnt;
		logic [`DPPC_CNT_W-1:0] vCnt;
		logic [`DPPC_FB_W-1:0] word;
		logic [`DPPC_FB_W-1:0] nextWord;
		logic wordFull;
		logic nextFull;
		logic [`DPPC_LANE_W-1:0] lane;
		logic fbReady;
		dppc_fetch_t fetchSt;
		logic [`DPPC_CUR_IDX_W-1:0] fetchIdx;
		logic rdReq;
		logic [`DPPC_ADDR_W-1:0] rdAddr;
		logic [9:0] dacR;
		logic [9:0] dacG;
		logic [9:0] dacB;
		logic blank;
		logic hs;
		logic vs;
		logic cs;
		logic monEn;
		logic tvEn;
		logic sclHold;
		logic sclOe;
		logic sdaOe;
		logic sclSmp;
		logic sdaSmp;
	} dppc_state_t;
endpackage

/* rtl/dppc_top.sv */
// Display pixel path: pixel decode, flicker filter, cursor, sync, serial lines.
// Assumes framebuffer words and cursor reads arrive synchronous to clk.
`timescale 1ns/1ps
`include "dppc_consts.svh"
module dppc_top #(
	parameter int LINE_MAX = `DPPC_LINE_MAX
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Framebuffer word stream
	input wire logic fbValid,
	input wire logic [`DPPC_FB_W-1:0] fbWord,
	input wire logic [1:0] fbWideSel,
	output logic fbReady,
	// Display timing, last counts and sync edges
	input wire logic [`DPPC_CNT_W-1:0] hActive,
	input wire logic [`DPPC_CNT_W-1:0] hSyncStart,
	input wire logic [`DPPC_CNT_W-1:0] hSyncEnd,
	input wire logic [`DPPC_CNT_W-1:0] hTotal,
	input wire logic [`DPPC_CNT_W-1:0] vActive,
	input wire logic [`DPPC_CNT_W-1:0] vSyncStart,
	input wire logic [`DPPC_CNT_W-1:0] vSyncEnd,
	input wire logic [`DPPC_CNT_W-1:0] vTotal,
	input wire logic tvMode,
	input wire logic flickerEn,
	// Gamma table write
	input wire logic lutWe,
	input wire logic [`DPPC_LUT_AW-1:0] lutAddr,
	input wire logic [23:0] lutData,
	// Cursor control
	input wire logic cursorEn,
	input wire logic [`DPPC_ADDR_W-1:0] cursorBase,
	input wire logic [`DPPC_CNT_W-1:0] cursorX,
	input wire logic [`DPPC_CNT_W-1:0] cursorY,
	// Cursor bitmap read from framebuffer
	output logic curRdReq,
	output logic [`DPPC_ADDR_W-1:0] curRdAddr,
	input wire logic curRdValid,
	input wire logic [15:0] curRdData,
	// Overlay video pixel for the current position
	input wire logic ovlValid,
	input wire logic [`DPPC_COL_W-1:0] ovlPix,
	// Serial lines, open drain
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic swSclLow,
	input wire logic swSdaLow,
	input wire logic swHold,
	output logic sclOut,
	output logic sclOe,
	output logic sdaOut,
	output logic sdaOe,
	output logic sclSample,
	output logic sdaSample,
	// DAC inputs and syncs
	output logic [9:0] dacRed,
	output logic [9:0] dacGreen,
	output logic [9:0] dacBlue,
	output logic dacBlank,
	output logic hsyncOut,
	output logic vsyncOut,
	output logic csyncOut,
	output logic monitorEn,
	output logic tvEnable
);
	localparam int LINE_AW = $clog2(LINE_MAX);

	dppc_pkg::dppc_state_t s, n;
	logic active, hsRaw, vsRaw, take, curHit;
	logic [`DPPC_LANE_W-1:0] laneLast;
	logic [`DPPC_PIX_W-1:0] pixSel;
	logic [`DPPC_COL_W-1:0] gfxColor, filtColor, underPix, mixPix;
	logic [`DPPC_CNT_W-1:0] rowY, dx, dy;
	logic [15:0] curPix;
	logic [LINE_AW-1:0] xIdx;
	logic [`DPPC_COL_W-1:0] lineA [LINE_MAX];
	logic [`DPPC_COL_W-1:0] lineB [LINE_MAX];
	logic [15:0] curRam [`DPPC_CUR_WORDS];

	// ==========================================================
	// Vertical blend 1/4, 1/2, 1/4: sums to one, so no clipping
	function automatic logic [`DPPC_COL_W-1:0] blend(
		input logic [`DPPC_COL_W-1:0] above,
		input logic [`DPPC_COL_W-1:0] mid,
		input logic [`DPPC_COL_W-1:0] below);
		logic [11:0] sum;
		blend = '0;
		for (int c = 0; c < 3; c++) begin
			sum = {2'h0, above[c*10 +: 10]} + {1'h0, mid[c*10 +: 10], 1'h0} +
				{2'h0, below[c*10 +: 10]};
			blend[c*10 +: 10] = sum[11:2];
		end
	endfunction

	// ==========================================================
	// Position, syncs and pixel selection
	assign active = (s.hCnt < hActive) && (s.vCnt < vActive);
	assign hsRaw = (s.hCnt >= hSyncStart) && (s.hCnt < hSyncEnd);
	assign vsRaw = (s.vCnt >= vSyncStart) && (s.vCnt < vSyncEnd);
	assign take = fbValid && s.fbReady;
	assign laneLast = (fbWideSel == 2'h2) ? 2'h3 : ((fbWideSel == 2'h1) ? 2'h1 : 2'h0);
	// Lane 0 is the low 32 bits, so pixels leave in little-endian order
	assign pixSel = s.wordFull ? s.word[{s.lane, 5'h00} +: `DPPC_PIX_W] : '0;
	assign xIdx = s.hCnt[LINE_AW-1:0];

	dppc_pixel_decode u_decode (
		.clk(clk),
		.pixel(pixSel),
		.lutWe(lutWe),
		.lutAddr(lutAddr),
		.lutData(lutData),
		.color(gfxColor)
	);

	// Filter sees graphics only; overlay then cursor are laid on after it
	assign filtColor = blend(lineB[xIdx], lineA[xIdx], gfxColor);
	assign underPix = ovlValid ? ovlPix : (flickerEn ? filtColor : gfxColor);

	// Filter output lags one line, so cursor rows follow that line
	assign rowY = flickerEn ? s.vCnt - 12'h001 : s.vCnt;
	assign dx = s.hCnt - cursorX;
	assign dy = rowY - cursorY;
	assign curHit = cursorEn && active && (dx < 12'(`DPPC_CUR_DIM)) &&
		(dy < 12'(`DPPC_CUR_DIM));
	assign curPix = curRam[{dy[4:0], dx[4:0]}];

	dppc_cursor_mix u_mix (
		.hit(curHit),
		.curPix(curPix),
		.under(underPix),
		.mixed(mixPix)
	);

	// ==========================================================
	// Line stores and cursor image store, no reset needed
	always_ff @(posedge clk) begin
		if (active) begin
			lineA[xIdx] <= gfxColor;
			lineB[xIdx] <= lineA[xIdx];
		end
		if (s.fetchSt == dppc_pkg::FETCH_WAIT && curRdValid) begin
			curRam[s.fetchIdx] <= curRdData;
		end
	end

	// ==========================================================
	// Next state of the whole block
	always_comb begin
		n = s;
		// Raster counters; hTotal and vTotal are the last counts
		if (s.hCnt == hTotal) begin
			n.hCnt = '0;
			n.vCnt = (s.vCnt == vTotal) ? '0 : s.vCnt + 12'h001;
		end else begin
			n.hCnt = s.hCnt + 12'h001;
		end
		// Two word slots so a 32-bit stream never starves between words
		if (active && s.wordFull) begin
			if (s.lane == laneLast) begin
				n.lane = '0;
				n.word = s.nextWord;
				n.wordFull = s.nextFull;
				n.nextFull = 1'h0;
			end else begin
				n.lane = s.lane + 2'h1;
			end
		end
		if (take) begin
			if (!n.wordFull) begin
				n.word = fbWord;
				n.wordFull = 1'h1;
			end else begin
				n.nextWord = fbWord;
				n.nextFull = 1'h1;
			end
		end
		n.fbReady = !n.nextFull;
		// Cursor image reload at the start of vertical retrace
		case (s.fetchSt)
			dppc_pkg::FETCH_IDLE: begin
				if (cursorEn && s.vCnt == vActive && s.hCnt == '0) begin
					n.fetchSt = dppc_pkg::FETCH_REQ;
					n.fetchIdx = '0;
				end
			end
			dppc_pkg::FETCH_REQ: begin
				n.fetchSt = dppc_pkg::FETCH_WAIT;
			end
			dppc_pkg::FETCH_WAIT: begin
				if (curRdValid) begin
					if (s.fetchIdx == '1) begin
						n.fetchSt = dppc_pkg::FETCH_IDLE;
					end else begin
						n.fetchIdx = s.fetchIdx + 10'h001;
						n.fetchSt = dppc_pkg::FETCH_REQ;
					end
				end
			end
			default: begin
				n.fetchSt = dppc_pkg::FETCH_IDLE;
			end
		endcase
		n.rdReq = (n.fetchSt == dppc_pkg::FETCH_REQ);
		n.rdAddr = cursorBase + `DPPC_ADDR_W'({n.fetchIdx, 1'h0});
		// DAC inputs, zero while blanked
		n.dacR = active ? mixPix[29:20] : '0;
		n.dacG = active ? mixPix[19:10] : '0;
		n.dacB = active ? mixPix[9:0] : '0;
		n.blank = !active;
		// One output type only: separate syncs or composite
		n.hs = !tvMode && hsRaw;
		n.vs = !tvMode && vsRaw;
		n.cs = tvMode && (hsRaw ^ vsRaw);
		n.monEn = !tvMode;
		n.tvEn = tvMode;
		// Hold clock low once seen low while software is busy
		n.sclHold = swHold && (s.sclHold || !sclIn);
		n.sclOe = swSclLow || n.sclHold;
		n.sdaOe = swSdaLow;
		n.sclSmp = sclIn;
		n.sdaSmp = sdaIn;
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// ==========================================================
	// Outputs straight from the state register; sclOut and sdaOut are tied low
	assign fbReady = s.fbReady;
	assign curRdReq = s.rdReq;
	assign curRdAddr = s.rdAddr;
	assign sclOut = 1'h0;
	assign sdaOut = 1'h0;
	assign sclOe = s.sclOe;
	assign sdaOe = s.sdaOe;
	assign sclSample = s.sclSmp;
	assign sdaSample = s.sdaSmp;
	assign dacRed = s.dacR;
	assign dacGreen = s.dacG;
	assign dacBlue = s.dacB;
	assign dacBlank = s.blank;
	assign hsyncOut = s.hs;
	assign vsyncOut = s.vs;
	assign csyncOut = s.cs;
	assign monitorEn = s.monEn;
	assign tvEnable = s.tvEn;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence retraceStart;
		cursorEn && s.vCnt == vActive && s.hCnt == '0 && s.fetchSt == dppc_pkg::FETCH_IDLE;
	endsequence
	sequence reqThenWait;
		curRdReq ##1 (!curRdReq && s.fetchSt == dppc_pkg::FETCH_WAIT);
	endsequence

	one_display_a: assert property (!(monitorEn && tvEnable))
		else $error("monitor and tv enabled together");
	comp_sync_a: assert property (tvEnable |-> (csyncOut == $past(hsRaw ^ vsRaw)
		&& !hsyncOut && !vsyncOut))
		else $error("composite sync wrong");
	lane_order_a: assert property ((s.wordFull && s.lane == 2'h0) |->
		pixSel == s.word[31:0])
		else $error("first pixel not low lane");
	bypass_pack_a: assert property (pixSel[`DPPC_BYPASS_BIT] |-> gfxColor ==
		{pixSel[23:16], pixSel[29:28], pixSel[15:8], pixSel[27:26],
		pixSel[7:0], pixSel[25:24]})
		else $error("bypass colour packing wrong");
	fetch_start_a: assert property (retraceStart |=> reqThenWait)
		else $error("cursor fetch did not start");
	fetch_window_a: assert property (curRdReq |-> (curRdAddr - cursorBase) <
		24'(`DPPC_CUR_BYTES))
		else $error("cursor read outside bitmap");
	cur_clear_a: assert property ((curHit && curPix == 16'h0000) |=>
		{dacRed, dacGreen, dacBlue} == $past(underPix))
		else $error("transparent cursor changed pixel");
	cur_invert_a: assert property ((curHit && curPix == `DPPC_CUR_INV) |=>
		{dacRed, dacGreen, dacBlue} == ~$past(underPix))
		else $error("cursor did not invert pixel");
	scl_stretch_a: assert property ((swHold && !sclIn) |=> (sclOe and
		(swHold |=> sclOe)))
		else $error("clock not held low");
	sda_drive_a: assert property (swSdaLow |=> sdaOe)
		else $error("data line not driven");
endmodule

/* sim/dppc_fb_model.sv */
// Framebuffer memory model that answers cursor bitmap word reads.
// Assumes one read in flight at a time, as the cursor fetch issues them.
`timescale 1ns/1ps
`include "dppc_consts.svh"
module dppc_fb_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Read request and model settings
	input wire logic curRdReq,
	input wire logic [`DPPC_ADDR_W-1:0] curRdAddr,
	input wire logic [`DPPC_ADDR_W-1:0] base,
	input wire logic [15:0] pattern,
	input wire logic [3:0] lat,
	// Answer and address watch
	output logic curRdValid,
	output logic [15:0] curRdData,
	output logic badAddr
);
	// ==========================================================
	// Answer lat cycles late; data toggles between answers so stale reads show
	int cnt;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 0;
			curRdValid <= 1'b0;
			curRdData <= 16'h0000;
			badAddr <= 1'b0;
		end else begin
			curRdValid <= 1'b0;
			curRdData <= ~curRdData;
			if (curRdReq) begin
				cnt <= lat;
				if (curRdAddr - base > 24'h0007FE || curRdAddr[0]) badAddr <= 1'b1;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
				if (cnt == 1) begin
					curRdValid <= 1'b1;
					curRdData <= pattern;
				end
			end
		end
	end
endmodule

/* sim/dppc_tb_top.sv */
// Self-checking bench for the display pixel path with cursor.
// Assumes the framebuffer model beside it; a 16x16 active raster.
`timescale 1ns/1ps
`include "dppc_consts.svh"
module dppc_tb_top;
	// ==========================================================
	// Stimulus and observed signals
	logic clk = 1'b0, rst = 1'b1, fbValid = 1'b1, tvMode = 1'b0, flickerEn = 1'b0;
	logic lutWe = 1'b0, cursorEn = 1'b0, ovlValid = 1'b0, swHold = 1'b0;
	logic swSclLow = 1'b0, swSdaLow = 1'b0, devSclLow = 1'b0, devSdaLow = 1'b0;
	logic [1:0] fbWideSel = 2'h0;
	logic [127:0] fbWord = 128'h0;
	logic [7:0] lutAddr = 8'h00;
	logic [23:0] lutData = 24'h0, cursorBase = 24'h1F0000, curRdAddr;
	logic [29:0] ovlPix = 30'h2A5C3E1F;
	logic [15:0] pattern = 16'h0000, curRdData;
	logic [3:0] lat = 4'h1;
	logic [11:0] cursorX = 12'h000, cursorY = 12'h000;
	// Line length 16 is a whole multiple at 32 bpp
	logic [11:0] tim [8] = '{16, 20, 26, 31, 16, 18, 20, 21};
	logic fbReady, curRdReq, curRdValid, badAddr, sclOe, sdaOe, sclSample, sdaSample;
	logic [9:0] dacRed, dacGreen, dacBlue;
	logic dacBlank, hsyncOut, vsyncOut, csyncOut, monitorEn, tvEnable, sclOut, sdaOut;
	wire sclIn, sdaIn;
	int n_mismatch = 0, checks = 0, cyc = 0;

	// Open-drain lines with pull-ups
	assign sclIn = ~(sclOe | devSclLow);
	assign sdaIn = ~(sdaOe | devSdaLow);

	// ==========================================================
	// Clock, hang limit, design and partner
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 95000) begin
			n_mismatch++;
			stop_test();
		end
	end
	dppc_top #(.LINE_MAX(64)) i_dut (.clk(clk), .rst(rst), .fbValid(fbValid),
		.fbWord(fbWord), .fbWideSel(fbWideSel), .fbReady(fbReady), .hActive(tim[0]),
		.hSyncStart(tim[1]), .hSyncEnd(tim[2]), .hTotal(tim[3]), .vActive(tim[4]),
		.vSyncStart(tim[5]), .vSyncEnd(tim[6]), .vTotal(tim[7]), .tvMode(tvMode),
		.flickerEn(flickerEn), .lutWe(lutWe), .lutAddr(lutAddr), .lutData(lutData),
		.cursorEn(cursorEn), .cursorBase(cursorBase), .cursorX(cursorX), .cursorY(cursorY),
		.curRdReq(curRdReq), .curRdAddr(curRdAddr), .curRdValid(curRdValid),
		.curRdData(curRdData), .ovlValid(ovlValid), .ovlPix(ovlPix), .sclIn(sclIn),
		.sdaIn(sdaIn), .swSclLow(swSclLow), .swSdaLow(swSdaLow), .swHold(swHold),
		.sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe), .sclSample(sclSample),
		.sdaSample(sdaSample), .dacRed(dacRed), .dacGreen(dacGreen), .dacBlue(dacBlue),
		.dacBlank(dacBlank), .hsyncOut(hsyncOut), .vsyncOut(vsyncOut),
		.csyncOut(csyncOut), .monitorEn(monitorEn), .tvEnable(tvEnable));
	dppc_fb_model i_mem (.clk(clk), .rst(rst), .curRdReq(curRdReq), .curRdAddr(curRdAddr),
		.base(cursorBase), .pattern(pattern), .lat(lat), .curRdValid(curRdValid),
		.curRdData(curRdData), .badAddr(badAddr));

	// ==========================================================
	// Expected-value helpers
	function automatic logic [29:0] byp(input logic [31:0] p);
		return {p[23:16], p[29:28], p[15:8], p[27:26], p[7:0], p[25:24]};
	endfunction
	function automatic logic [29:0] mix(input logic [29:0] u, input logic [15:0] c);
		logic [29:0] w;
		w = {c[14:10], c[14:10], c[9:5], c[9:5], c[4:0], c[4:0]};
		if (c == 16'h0000) return u;
		return c[15] ? w : (u ^ w);
	endfunction

	// ==========================================================
	// Bench primitives; inputs move 2 ns after the edge
	task automatic tick();
		@(posedge clk);
		#2;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic vrise();
		int i;
		for (i = 0; i < 1000 && vsyncOut !== 1'b0; i++) tick();
		for (i = 0; i < 1000 && vsyncOut !== 1'b1; i++) tick();
		chk("vsync rise", 1, vsyncOut);
	endtask
	task automatic wait_req(input logic [23:0] a);
		int i;
		for (i = 0; i < 9000 && !(curRdReq === 1'b1 && curRdAddr === a); i++) tick();
		chk("cursor request", {1'b1, a}, {curRdReq, curRdAddr});
	endtask
	// Two frames flush buffered words; then 8 pixels of the first line
	task automatic check_px(input string what, input logic [29:0] e [4], input int nl);
		int i;
		vrise();
		vrise();
		for (i = 0; i < 1000 && dacBlank !== 1'b0; i++) tick();
		for (i = 0; i < 8; i++) begin
			chk(what, e[i % nl], {dacRed, dacGreen, dacBlue});
			tick();
		end
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_pixels();
		logic [29:0] e;
		fbWord = {96'hFFFF0000FFFF0000FFFF0000, 32'hE9A5C3E1};
		e = byp(32'hE9A5C3E1);
		check_px("bypass pixel", '{e, e, e, e}, 1);
		lutWe = 1'b1;
		lutAddr = 8'h12;
		lutData = 24'hA1B2C3;
		tick();
		lutAddr = 8'h34;
		lutData = 24'hD4E5F6;
		tick();
		lutAddr = 8'h56;
		lutData = 24'h172839;
		tick();
		lutWe = 1'b0;
		fbWord[31:0] = 32'h7F123456;
		e = {8'hA1, 2'h0, 8'hE5, 2'h0, 8'h39, 2'h0};
		check_px("gamma pixel", '{e, e, e, e}, 1);
		flickerEn = 1'b1;
		check_px("filtered pixel", '{e, e, e, e}, 1);
		flickerEn = 1'b0;
		$display("test pixel decode done");
	endtask
	task automatic t_wide();
		// Width goes to 64 and then 128 bits only in blanking, so each frame starts on lane 0
		vrise();
		fbWideSel = 2'h1;
		fbWord = {64'h0, 32'h83405060, 32'h80102030};
		check_px("64-bit lane", '{byp(32'h80102030), byp(32'h83405060), 0, 0}, 2);
		vrise();
		fbWideSel = 2'h2;
		fbWord = {32'hBF0F0F0F, 32'hAAF00F00, 32'h95123456, 32'h80102030};
		check_px("128-bit lane", '{byp(32'h80102030), byp(32'h95123456),
			byp(32'hAAF00F00), byp(32'hBF0F0F0F)}, 4);
		fbWideSel = 2'h0;
		$display("test wide words done");
	endtask
	task automatic t_cursor();
		logic [15:0] pat [4] = '{16'h0000, 16'h9234, 16'h1234, 16'h7FFF};
		logic [29:0] u, e;
		int i;
		u = byp(fbWord[31:0]);
		cursorEn = 1'b1;
		for (i = 0; i < 4; i++) begin
			vrise();
			pattern = pat[i];
			lat = (i == 1) ? 4'h3 : 4'h1;
			ovlValid = (i == 2);
			wait_req(cursorBase);
			wait_req(cursorBase + 24'h0007FE);
			e = mix(ovlValid ? ovlPix : u, pat[i]);
			check_px("cursor pixel", '{e, e, e, e}, 1);
		end
		ovlValid = 1'b0;
		// Last image inverts; a cursor moved off the first 8 pixels of line 0 must leave them plain
		vrise();
		cursorX = 12'h008;
		check_px("cursor x pixel", '{u, u, u, u}, 1);
		vrise();
		cursorX = 12'h000;
		cursorY = 12'h001;
		check_px("cursor y pixel", '{u, u, u, u}, 1);
		vrise();
		cursorY = 12'h000;
		cursorEn = 1'b0;
		check_px("cursor off pixel", '{u, u, u, u}, 1);
		chk("cursor read range", 0, badAddr);
		$display("test cursor done");
	endtask
	// One frame is 32 x 22 cycles; sync cycle counts are phase-free
	task automatic t_sync();
		int m, i, n [4];
		for (m = 0; m < 2; m++) begin
			tvMode = m[0];
			tick();
			tick();
			n = '{0, 0, 0, 0};
			for (i = 0; i < 704; i++) begin
				n[0] += (hsyncOut === 1'b1);
				n[1] += (vsyncOut === 1'b1);
				n[2] += (csyncOut === 1'b1);
				n[3] += (monitorEn === tvEnable);
				tick();
			end
			chk("hsync cycles", m ? 0 : 132, n[0]);
			chk("vsync cycles", m ? 0 : 64, n[1]);
			chk("csync cycles", m ? 172 : 0, n[2]);
			chk("both displays", 0, n[3]);
			chk("tv enable", m, tvEnable);
		end
		tvMode = 1'b0;
		$display("test sync done");
	endtask
	task automatic t_serial();
		swSclLow = 1'b1;
		devSdaLow = 1'b1;
		tick();
		tick();
		chk("clock pull", 2, {sclOe, sclSample});
		chk("data sample", 0, {sdaOe, sdaSample});
		chk("line drive level", 0, {sclOut, sdaOut});
		swSclLow = 1'b0;
		devSdaLow = 1'b0;
		swSdaLow = 1'b1;
		tick();
		chk("data drive", 3, {sdaOe, sdaSample});
		// Clock is released again before the hold starts, so only the far pull can trip it
		swSdaLow = 1'b0;
		swHold = 1'b1;
		tick();
		devSclLow = 1'b1;
		tick();
		tick();
		devSclLow = 1'b0;
		tick();
		tick();
		chk("clock stretch", 2, {sclOe, sclSample});
		swHold = 1'b0;
		tick();
		tick();
		chk("clock release", 1, {sclOe, sclSample});
		$display("test serial done");
	endtask

	// ==========================================================
	// Verdict and main sequence
	task automatic stop_test();
		$display("Checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		#2;
		chk("reset outputs", 0, {fbReady, monitorEn, tvEnable, curRdReq, sclOe, dacBlank});
		rst = 1'b0;
		tick();
		tick();
		chk("monitor enable", 2, {monitorEn, tvEnable});
		chk("word ready", 1, fbReady);
		$display("test reset done");
		t_pixels();
		t_wide();
		t_cursor();
		t_sync();
		t_serial();
		stop_test();
	end
endmodule
